// [hdl/hsrp_pkg.sv]
package hsrp_pkg;
   // ==========================================================
   // byte framing and control byte layout
   localparam int          BYTE_W       = 8;
   localparam logic [2:0]  LAST_BIT     = 3'h7;
   localparam int          CTRL_RD_BIT  = 7;
   localparam int          CTRL_ADDR_LO = 0;
   localparam int          ADDR_W       = 4;
   localparam int          NUM_REGS     = 16;
   // ==========================================================
   // register map
   localparam logic [3:0]  ADDR_RESET   = 4'h0;
   localparam logic [3:0]  ADDR_TXQ     = 4'hE;
   localparam logic [3:0]  ADDR_RXQ     = 4'hE;
   localparam int          TXQ_DEPTH    = 33;
   // ==========================================================
   // timing
   localparam int          MCLK_PS      = 5000;
   localparam int          SCK_HALF_PS  = 40000;
   localparam int          SCK_HALF_CYC = (SCK_HALF_PS + MCLK_PS - 1)
                                          / MCLK_PS;
   // ==========================================================
   // host sequencer states
   typedef enum logic [4:0] {
      HST_IDLE = 5'h01,
      HST_CTRL = 5'h02,
      HST_GAP  = 5'h04,
      HST_DATA = 5'h08,
      HST_DONE = 5'h10
   } hsrp_host_state_e;
endpackage : hsrp_pkg

// [hdl/hsrp_if.sv]
`timescale 1ns/1ps
interface hsrp_if;
   logic sck;
   logic cs_n;
   logic sel;
   logic cmd_data;
   logic host_dq_o;
   logic host_dq_oe;
   logic dev_dq_o;
   logic dev_dq_oe;
   logic so_o;
   logic so_oe;
   logic host_data_bidir;
   logic so_line;

   // ==========================================================
   // wire resolution, undriven lines rest high (pull-up)
   assign host_data_bidir = dev_dq_oe  ? dev_dq_o  :
                            host_dq_oe ? host_dq_o : 1'b1;
   assign so_line         = so_oe ? so_o : 1'b1;

   modport dev  (input  sck, cs_n, sel, cmd_data, host_data_bidir,
                 output dev_dq_o, dev_dq_oe, so_o, so_oe);
   modport host (output sck, cs_n, sel, cmd_data, host_dq_o,
                 host_dq_oe,
                 input  host_data_bidir, so_line);
endinterface : hsrp_if

// [hdl/hsrp_host.sv]
`timescale 1ns/1ps
module hsrp_host #(
   parameter int HALF = hsrp_pkg::SCK_HALF_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rstn,
   hsrp_if.host            bus,
   input  wire logic       wire3_mode,
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic [3:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data
);
   localparam int PW = $clog2(2 * HALF + 1);
   localparam logic [PW-1:0] PH_RISE = PW'(HALF);
   localparam logic [PW-1:0] PH_END  = PW'(2 * HALF - 1);

   typedef struct packed {
      hsrp_pkg::hsrp_host_state_e state;
      logic [1:0]                 dq_s;
      logic [1:0]                 so_s;
      logic                       sck;
      logic                       cs_n;
      logic                       sel;
      logic                       cd;
      logic                       dq_o;
      logic                       dq_oe;
      logic [PW-1:0]              phase;
      logic [2:0]                 bitn;
      logic [7:0]                 sh;
      logic [7:0]                 wdata;
      logic                       rd;
      logic                       cmd_ready;
      logic                       rsp_valid;
      logic [7:0]                 rsp_data;
   } hsrp_host_s;

   hsrp_host_s r_reg;
   hsrp_host_s r_next;
   logic       rx_bit;
   logic       byte_end;

   // ==========================================================
   // sequencer
   always_comb begin
      r_next           = r_reg;
      r_next.dq_s      = {r_reg.dq_s[0], bus.host_data_bidir};
      r_next.so_s      = {r_reg.so_s[0], bus.so_line};
      r_next.rsp_valid = 1'b0;
      rx_bit   = r_reg.sel ? r_reg.so_s[1] : r_reg.dq_s[1];
      byte_end = 1'b0;
      if (r_reg.state == hsrp_pkg::HST_CTRL ||
          r_reg.state == hsrp_pkg::HST_DATA) begin
         r_next.phase = PW'(r_reg.phase + 1'b1);
         if (r_reg.phase == '0) begin
            r_next.sck   = 1'b0;
            r_next.dq_o  = r_reg.sh[0];                  // [R17]
         end
         if (r_reg.phase == PH_RISE) begin
            r_next.sck = 1'b1;
            r_next.sh  = {rx_bit, r_reg.sh[7:1]};        // [R17]
         end
         if (r_reg.phase == PH_END) begin
            r_next.phase = '0;
            r_next.bitn  = 3'(r_reg.bitn + 1'b1);
            byte_end     = (r_reg.bitn == hsrp_pkg::LAST_BIT);
         end
      end
      case (r_reg.state)
         hsrp_pkg::HST_IDLE: begin
            r_next.cs_n   = 1'b1;
            r_next.sel    = wire3_mode;                  // [R1]
            r_next.dq_oe  = 1'b1;
            r_next.dq_o   = 1'b1;
            if (cmd_valid && r_reg.cmd_ready) begin
               r_next.cmd_ready = 1'b0;
               r_next.cs_n      = 1'b0;
               r_next.cd        = 1'b1;                  // [R7]
               r_next.rd        = cmd_read;
               r_next.wdata     = cmd_wdata;
               r_next.sh        = {cmd_read, 3'h0, cmd_addr}; // [R17]
               r_next.phase     = '0;
               r_next.bitn      = '0;
               r_next.state     = hsrp_pkg::HST_CTRL;
            end
         end
         hsrp_pkg::HST_CTRL: begin
            if (byte_end) begin
               r_next.cd     = 1'b0;                     // [R10] [R12]
               r_next.sh     = r_reg.wdata;
               // two-wire read: let go before the device drives
               r_next.dq_oe  = r_reg.sel | ~r_reg.rd;    // [R14]
               r_next.state  = hsrp_pkg::HST_GAP;
            end
         end
         hsrp_pkg::HST_GAP: begin
            r_next.phase = PW'(r_reg.phase + 1'b1);
            if (r_reg.phase == PH_END) begin
               r_next.phase = '0;
               r_next.state = hsrp_pkg::HST_DATA;
            end
         end
         hsrp_pkg::HST_DATA: begin
            if (byte_end) begin
               r_next.cd        = 1'b1;
               r_next.rsp_valid = r_reg.rd;
               // all eight bits were shifted in at the rising edges
               r_next.rsp_data  = r_reg.sh;              // [R17]
               r_next.state     = hsrp_pkg::HST_DONE;
            end
         end
         hsrp_pkg::HST_DONE: begin
            // device needs a few cycles to see control mode again
            r_next.phase = PW'(r_reg.phase + 1'b1);
            if (r_reg.phase == PH_END) begin
               r_next.phase     = '0;
               r_next.cmd_ready = 1'b1;
               r_next.state     = hsrp_pkg::HST_IDLE;
            end
         end
         default: begin
            r_next.state = hsrp_pkg::HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r_reg           <= '0;
         r_reg.state     <= hsrp_pkg::HST_IDLE;
         r_reg.sck       <= 1'b1;
         r_reg.cs_n      <= 1'b1;
         r_reg.dq_o      <= 1'b1;
         r_reg.cmd_ready <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.sck         = r_reg.sck;
   assign bus.cs_n        = r_reg.cs_n;
   assign bus.sel         = r_reg.sel;
   assign bus.cmd_data    = r_reg.cd;
   assign bus.host_dq_o   = r_reg.dq_o;
   assign bus.host_dq_oe  = r_reg.dq_oe;
   assign cmd_ready       = r_reg.cmd_ready;
   assign rsp_valid       = r_reg.rsp_valid;
   assign rsp_data        = r_reg.rsp_data;
endmodule : hsrp_host

// [hdl/hsrp_dev.sv]
`timescale 1ns/1ps
// How it works
// [R1] select pin high three-wire, low two-wire
// [R2] three-wire read: next bit on falling edge
// [R3] three-wire write: sample rising, output one
// [R4] two-wire read: device drives shared line
// [R5] two-wire write: line input, rising capture
// [R6] two-wire: out pin released, in shared
// [R7] command/data high: address and direction set
// [R8] after reset, writes target address zero
// [R9] control byte taken after eight clocks only
// [R10] low after read select enters read mode
// [R11] raising command/data clears the bit counter
// [R12] low after write select enters write mode
// [R13] register updated on eighth rising edge
// [R14] host never drives while device outputs
// [R15] separate write and read register maps
// [R16] transmit address writes fill 33-byte queue
// [R17] least significant bit first, fixed layout
module hsrp_dev #(
   parameter int TX_DEPTH = hsrp_pkg::TXQ_DEPTH
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   hsrp_if.dev                   bus,
   input  wire logic [15:0][7:0] rd_regs,
   input  wire logic             rx_valid,
   input  wire logic [7:0]       rx_data,
   output logic                  rx_pop,
   output logic [15:0][7:0]      wr_regs,
   output logic                  wr_stb,
   output logic [3:0]            wr_addr,
   input  wire logic             tx_ready,
   output logic                  tx_valid,
   output logic [7:0]            tx_data,
   output logic [$clog2(TX_DEPTH+1)-1:0] tx_level,
   output logic                  tx_overflow,
   input  wire logic             tx_overflow_clr,
   output logic                  rx_underrun,
   input  wire logic             rx_underrun_clr
);
   localparam int CW = $clog2(TX_DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(TX_DEPTH);

   typedef struct packed {
      logic [2:0]                sck_s;
      logic [1:0]                cs_s;
      logic [1:0]                sel_s;
      logic [1:0]                cd_s;
      logic [1:0]                si_s;
      logic                      cd_q;
      logic [2:0]                bitcnt;
      logic [7:0]                shreg;
      logic [3:0]                addr;
      logic                      rd;
      logic                      so_o;
      logic                      so_oe;
      logic                      dq_o;
      logic                      dq_oe;
      logic [15:0][7:0]          wregs;
      logic                      wr_stb;
      logic [3:0]                wr_addr;
      logic [TX_DEPTH-1:0][7:0]  txq;
      logic [CW-1:0]             tx_cnt;
      logic                      tx_valid;
      logic                      tx_ovf;
      logic                      rx_pop;
      logic                      rx_unr;
   } hsrp_dev_s;

   hsrp_dev_s  r_reg;
   hsrp_dev_s  r_next;
   logic       rise;
   logic       fall;
   logic       sel3;
   logic       cd;
   logic       cs;
   logic [7:0] in_byte;
   logic [7:0] out_byte;
   logic [CW-1:0] cnt;
   logic       ovf_set;
   logic       unr_set;

   // ==========================================================
   // serial engine
   always_comb begin
      r_next        = r_reg;
      // only stage 1 of each chain reaches logic, except the clock chain, where stages 1 and 2 both do
      r_next.sck_s  = {r_reg.sck_s[1:0], bus.sck};
      r_next.cs_s   = {r_reg.cs_s[0], bus.cs_n};
      r_next.sel_s  = {r_reg.sel_s[0], bus.sel};
      r_next.cd_s   = {r_reg.cd_s[0], bus.cmd_data};
      r_next.si_s   = {r_reg.si_s[0], bus.host_data_bidir};
      rise     = r_reg.sck_s[1] & ~r_reg.sck_s[2];
      fall     = ~r_reg.sck_s[1] & r_reg.sck_s[2];
      sel3     = r_reg.sel_s[1];
      cd       = r_reg.cd_s[1];
      cs       = ~r_reg.cs_s[1];
      in_byte  = {r_reg.si_s[1], r_reg.shreg[7:1]};      // [R17]
      out_byte = rd_regs[r_reg.addr];
      cnt      = r_reg.tx_cnt;
      ovf_set  = 1'b0;
      unr_set  = 1'b0;
      r_next.cd_q   = cd;
      r_next.wr_stb = 1'b0;
      r_next.rx_pop = 1'b0;
      // queue drains toward slot 0 while the user side takes it
      if (tx_ready && r_reg.tx_valid) begin
         for (int i = 0; i < TX_DEPTH - 1; i++) begin
            r_next.txq[i] = r_reg.txq[i + 1];
         end
         cnt = CW'(cnt - 1'b1);
      end
      if (!cs) begin
         r_next.bitcnt = '0;
      end else if (cd != r_reg.cd_q) begin
         // a short group is dropped on any mode change
         r_next.bitcnt = '0;                             // [R11] [R9]
      end else if (cd || !r_reg.rd) begin
         r_next.so_o  = 1'b1;                            // [R3]
         r_next.dq_o  = 1'b1;
         if (rise) begin
            r_next.shreg  = in_byte;                     // [R3] [R5]
            r_next.bitcnt = 3'(r_reg.bitcnt + 1'b1);
            if (r_reg.bitcnt == hsrp_pkg::LAST_BIT) begin
               if (cd) begin
                  r_next.addr = in_byte[hsrp_pkg::CTRL_ADDR_LO +:
                                        hsrp_pkg::ADDR_W];  // [R7] [R9]
                  r_next.rd   = in_byte[hsrp_pkg::CTRL_RD_BIT]; // [R17]
               end else if (r_reg.addr == hsrp_pkg::ADDR_TXQ) begin
                  if (cnt != FULL) begin
                     r_next.txq[cnt] = in_byte;          // [R16]
                     cnt = CW'(cnt + 1'b1);
                  end else begin
                     ovf_set = 1'b1;
                  end
               end else begin
                  r_next.wregs[r_reg.addr] = in_byte;    // [R13] [R12]
                  r_next.wr_stb  = 1'b1;
                  r_next.wr_addr = r_reg.addr;
               end
            end
         end
      end else if (fall) begin
         r_next.bitcnt = 3'(r_reg.bitcnt + 1'b1);        // [R10]
         if (r_reg.bitcnt == '0) begin
            // a fresh byte: receive queue advances once per byte
            if (r_reg.addr == hsrp_pkg::ADDR_RXQ) begin  // [R15]
               out_byte      = rx_valid ? rx_data : 8'h00;
               r_next.rx_pop = rx_valid;                 // [R15]
               unr_set       = ~rx_valid;
            end
            r_next.so_o  = out_byte[0];                  // [R2] [R17]
            r_next.dq_o  = out_byte[0];                  // [R4]
            r_next.shreg = {1'b0, out_byte[7:1]};
         end else begin
            r_next.so_o  = r_reg.shreg[0];               // [R2]
            r_next.dq_o  = r_reg.shreg[0];               // [R4]
            r_next.shreg = {1'b0, r_reg.shreg[7:1]};
         end
      end
      r_next.so_oe  = cs & sel3;                         // [R1] [R6]
      // drive the shared line only while reading in two-wire mode
      r_next.dq_oe  = cs & ~sel3 & ~cd & r_reg.rd;       // [R4] [R5] [R14]
      r_next.tx_cnt   = cnt;
      r_next.tx_valid = (cnt != '0);
      // a new event wins over a clear in the same cycle
      r_next.tx_ovf = ovf_set | (r_reg.tx_ovf & ~tx_overflow_clr);
      r_next.rx_unr = unr_set | (r_reg.rx_unr & ~rx_underrun_clr);
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r_reg       <= '0;                              // [R8]
         r_reg.sck_s <= 3'h7;
         r_reg.cs_s  <= 2'h3;
         r_reg.so_o  <= 1'b1;
         r_reg.dq_o  <= 1'b1;
         r_reg.addr  <= hsrp_pkg::ADDR_RESET;            // [R8]
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.so_o       = r_reg.so_o;
   assign bus.so_oe      = r_reg.so_oe;
   assign bus.dev_dq_o   = r_reg.dq_o;
   assign bus.dev_dq_oe  = r_reg.dq_oe;
   assign rx_pop         = r_reg.rx_pop;
   assign wr_regs        = r_reg.wregs;
   assign wr_stb         = r_reg.wr_stb;
   assign wr_addr        = r_reg.wr_addr;
   assign tx_valid       = r_reg.tx_valid;
   assign tx_data        = r_reg.txq[0];
   assign tx_level       = r_reg.tx_cnt;
   assign tx_overflow    = r_reg.tx_ovf;
   assign rx_underrun    = r_reg.rx_unr;
endmodule : hsrp_dev

// [testbench/hsrp_chk.sv]
`timescale 1ns/1ps
module hsrp_chk (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sel,
   input wire logic cmd_data,
   input wire logic host_dq_oe,
   input wire logic dev_dq_o,
   input wire logic dev_dq_oe,
   input wire logic so_o,
   input wire logic so_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ==========
   // pin states
   // six cycles leave room for the device's pin synchroniser
   AST_SO_RELEASED:
   assert property ((cs_n || !sel) [*6] |-> !so_oe)
      else $error("output pin driven while released");
   AST_SO_CTRL_ONE:
   assert property ((sel && !cs_n && cmd_data) [*6] |-> so_oe && so_o)
      else $error("output pin not one in control mode");
   AST_NO_CLASH:
   assert property (!(dev_dq_oe && host_dq_oe))
      else $error("both ends drive shared line");
   AST_SHARED_ONLY_TWO:
   assert property (dev_dq_oe |-> !sel && !cs_n)
      else $error("shared line driven outside two-wire");
   AST_SHARED_IN_CTRL:
   assert property ((cmd_data && !cs_n) [*6] |-> !dev_dq_oe)
      else $error("shared line driven in control mode");
   // ==========
   // edge timing
   AST_SO_ON_FALL:
   assert property (so_oe && $past(so_oe) && $changed(so_o) && !cmd_data
                    && !$past(cmd_data, 6) |-> !sck)
      else $error("output bit moved while clock high");
   AST_DQ_ON_FALL:
   assert property (dev_dq_oe && $past(dev_dq_oe) && $changed(dev_dq_o)
                    |-> !sck)
      else $error("shared bit moved while clock high");
   AST_HALF_LOW:
   assert property ($fell(sck) |=> !sck [*7] ##1 sck)
      else $error("serial clock low phase not eight cycles");
   AST_MODE_AT_HIGH:
   assert property ($changed(cmd_data) && !cs_n |-> sck)
      else $error("mode pin moved while clock low");
   // ==========
   // coverage
   cover property ($rose(dev_dq_oe));
   cover property (so_oe && !so_o && !cmd_data);
   cover property ($rose(cmd_data) && !cs_n);
endmodule : hsrp_chk

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic             mclk = 1'b0;
   logic             rstn = 1'b0;
   logic             wire3_mode = 1'b1;
   logic             cmd_valid = 1'b0;
   logic             cmd_read = 1'b0;
   logic [3:0]       cmd_addr = 4'h0;
   logic [7:0]       cmd_wdata = 8'h00;
   logic             cmd_ready, rsp_valid, rx_pop, wr_stb, tx_valid;
   logic [7:0]       rsp_data, tx_data, ctl_sh, dat_sh;
   logic [15:0][7:0] rd_regs, wr_regs;
   logic             rx_valid = 1'b0;
   logic [7:0]       rx_data = 8'h00;
   logic             tx_ready = 1'b0;
   logic [3:0]       wr_addr;
   logic [5:0]       tx_level;
   logic             tx_overflow, rx_underrun, rd_now;
   logic             tx_overflow_clr = 1'b0;
   logic             rx_underrun_clr = 1'b0;
   int               fails = 0, total_checks = 0;
   int               n_stb = 0, n_pop = 0, n_tx = 0;

   always #2.5 mclk = ~mclk;
   // ==========
   // both ends on one carrier
   hsrp_if u_hsrp_if ();
   hsrp_host #(.HALF(8)) u_hsrp_host (.mclk(mclk), .rstn(rstn),
      .bus(u_hsrp_if.host), .wire3_mode(wire3_mode),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   hsrp_dev u_hsrp_dev (.mclk(mclk), .rstn(rstn), .bus(u_hsrp_if.dev),
      .rd_regs(rd_regs), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_pop(rx_pop), .wr_regs(wr_regs), .wr_stb(wr_stb),
      .wr_addr(wr_addr), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_level(tx_level), .tx_overflow(tx_overflow),
      .tx_overflow_clr(tx_overflow_clr), .rx_underrun(rx_underrun),
      .rx_underrun_clr(rx_underrun_clr));
   hsrp_chk u_hsrp_chk (.mclk(mclk), .rstn(rstn), .sck(u_hsrp_if.sck),
      .cs_n(u_hsrp_if.cs_n), .sel(u_hsrp_if.sel),
      .cmd_data(u_hsrp_if.cmd_data), .host_dq_oe(u_hsrp_if.host_dq_oe),
      .dev_dq_o(u_hsrp_if.dev_dq_o), .dev_dq_oe(u_hsrp_if.dev_dq_oe),
      .so_o(u_hsrp_if.so_o), .so_oe(u_hsrp_if.so_oe));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // ==========
   // wire watch: bytes rebuilt lsb first at each rising clock
   always @(posedge u_hsrp_if.sck) begin
      if (u_hsrp_if.cs_n === 1'b0 && u_hsrp_if.cmd_data === 1'b1)
         ctl_sh = {u_hsrp_if.host_data_bidir, ctl_sh[7:1]};
      if (u_hsrp_if.cs_n === 1'b0 && u_hsrp_if.cmd_data === 1'b0) begin
         dat_sh = {(u_hsrp_if.sel && rd_now) ? u_hsrp_if.so_line
                   : u_hsrp_if.host_data_bidir, dat_sh[7:1]};
         if (u_hsrp_if.sel && !rd_now)
            check(u_hsrp_if.so_line, 1'b1);
      end
   end

   // pulses counted at the falling mclk edge, away from the launching edge, where they are settled
   always @(negedge mclk) begin
      if (wr_stb === 1'b1)
         n_stb++;
      if (rx_pop === 1'b1)
         n_pop++;
   end

   // one transfer: writes d, or reads and expects d
   task automatic xfer(input logic rd, input logic [3:0] a,
                       input logic [7:0] d);
      logic [7:0] got;
      got = 8'h00;
      @(negedge mclk);
      rd_now = rd;
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge mclk);
      cmd_valid = 1'b0;
      repeat (2) @(negedge mclk);
      for (int i = 0; i < 1000 && cmd_ready !== 1'b1; i++) begin
         @(negedge mclk);
         if (rsp_valid === 1'b1)
            got = rsp_data;
      end
      check(cmd_ready, 1'b1);
      check(ctl_sh, {rd, 3'h0, a});
      check(dat_sh, d);
      if (rd)
         check(got, d);
   endtask : xfer

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      @(negedge mclk);
   endtask : pulse

   initial begin
      rd_now = 1'b0;
      for (int i = 0; i < 16; i++)
         rd_regs[i] = 8'(8'h90 + i);
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      check(wr_regs[0], 8'h00);
      check(u_hsrp_if.so_line, 1'b1);
      for (int m = 1; m >= 0; m--) begin
         wire3_mode = m[0];
         // a different value per mode, so each write is seen to land
         xfer(1'b0, 4'h3, 8'hA5 ^ {8{m[0]}});
         check(u_hsrp_if.sel, m[0]);
         check(wr_regs[3], 8'hA5 ^ {8{m[0]}});
         check(wr_addr, 4'h3);
         xfer(1'b0, 4'h5, 8'h3C);
         xfer(1'b1, 4'h5, 8'h95);
         check(wr_regs[5], 8'h3C);
      end
      check(16'(n_stb), 16'h0004);
      // far side stalls while the queue fills past full
      for (int k = 0; k <= hsrp_pkg::TXQ_DEPTH; k++)
         xfer(1'b0, 4'hE, 8'(8'h40 + k));
      check(tx_level, 6'h21);
      check(tx_overflow, 1'b1);
      check(wr_regs[14], 8'h00);
      pulse(tx_overflow_clr);
      check(tx_overflow, 1'b0);
      tx_ready = 1'b1;
      for (int k = 0; k < 200 && n_tx < 33; k++) begin
         if (tx_valid === 1'b1) begin
            check(tx_data, 8'(8'h40 + n_tx));
            n_tx++;
         end
         @(negedge mclk);
      end
      tx_ready = 1'b0;
      check(16'(n_tx), 16'h0021);
      check(tx_level, 6'h00);
      rx_valid = 1'b1;
      rx_data = 8'h5A;
      xfer(1'b1, 4'hE, 8'h5A);
      check(16'(n_pop), 16'h0001);
      rx_valid = 1'b0;
      xfer(1'b1, 4'hE, 8'h00);
      check(rx_underrun, 1'b1);
      pulse(rx_underrun_clr);
      check(rx_underrun, 1'b0);
      end_of_test();
   end

   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      end_of_test();
   end
endmodule : testbench
